//--- cstp_map.svh
`ifndef CSTP_MAP_SVH
`define CSTP_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define CSTP_OFF_LO_CTRL 4'h0
`define CSTP_OFF_HI_CTRL 4'h1
`define CSTP_OFF_LO_CNT 4'h2
`define CSTP_OFF_HI_CNT 4'h3
`define CSTP_OFF_LO_PER 4'h4
`define CSTP_OFF_HI_PER 4'h5

// ****************************************
// control field positions
// ****************************************
`define CSTP_BIT_RUN 15
`define CSTP_BIT_IDLE 13
`define CSTP_BIT_GATE 6
`define CSTP_BIT_PS_HI 5
`define CSTP_BIT_PS_LO 4
`define CSTP_BIT_JOIN 3
`define CSTP_BIT_CKSRC 1

// implemented bits per control register
`define CSTP_LO_CTRL_MASK 16'ha07a
`define CSTP_HI_CTRL_MASK 16'ha072

// ****************************************
// reset values
// ****************************************
`define CSTP_CTRL_RST 16'h0000
`define CSTP_CNT_RST 16'h0000
`define CSTP_PER_RST 16'hffff

// ****************************************
// prescaler terminal counts
// ****************************************
`define CSTP_PS_T1 8'h00
`define CSTP_PS_T8 8'h07
`define CSTP_PS_T64 8'h3f
`define CSTP_PS_T256 8'hff

`endif

//--- cstp_pkg.sv
package cstp_pkg;

    // decoded view of one control word
    typedef struct packed {
        logic run;
        logic idle_halt;
        logic gate;
        logic [1:0] prescale;
        logic pair_join;
        logic clk_src;
    } cstp_ctrl_s;

    typedef enum logic [1:0] {
        CSTP_PS_DIV1 = 2'h0,
        CSTP_PS_DIV8 = 2'h1,
        CSTP_PS_DIV64 = 2'h2,
        CSTP_PS_DIV256 = 2'h3
    } cstp_ps_e;

endpackage : cstp_pkg

//--- cstp_timer_pair.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "cstp_map.svh"

// ****************************************
// cascadable timer pair
// ****************************************
module cstp_timer_pair #(
    parameter int PAIR_SEL = 0
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    input wire logic I_IDLE,
    input wire logic I_LO_EXT_CLK,
    input wire logic I_HI_EXT_CLK,
    input wire logic I_LO_GATE,
    input wire logic I_HI_GATE,
    output logic O_LO_PERIOD_IRQ,
    output logic O_HI_PERIOD_IRQ,
    output logic O_ADC_TRIG,
    output logic O_DMA_REQ_LO,
    output logic O_DMA_REQ_HI,
    output logic [15:0] O_LO_TIMEBASE,
    output logic [15:0] O_HI_TIMEBASE
);

    // ****************************************
    // state
    // ****************************************
    logic [15:0] ctl_q [2];
    logic [15:0] cnt_q [2];
    logic [15:0] per_q [2];
    logic [7:0] pre_q [2];
    logic [2:0] ext_q [2];
    logic [1:0] irq_q;
    logic [15:0] rdata_q;

    cstp_pkg::cstp_ctrl_s lo_c;
    cstp_pkg::cstp_ctrl_s hi_c;
    logic joined;
    logic [1:0] ext_edge;
    logic [1:0] run_en;
    logic [1:0] base_en;
    logic [1:0] tick;
    logic [31:0] cnt32;
    logic [31:0] per32;
    logic adc_en;
    logic dma_en;

    // ****************************************
    // functions
    // ****************************************
    function automatic cstp_pkg::cstp_ctrl_s f_decode(input logic [15:0] w);
        cstp_pkg::cstp_ctrl_s r;
        r.run = w[`CSTP_BIT_RUN];
        r.idle_halt = w[`CSTP_BIT_IDLE];
        r.gate = w[`CSTP_BIT_GATE];
        r.prescale = w[`CSTP_BIT_PS_HI:`CSTP_BIT_PS_LO];
        r.pair_join = w[`CSTP_BIT_JOIN];
        r.clk_src = w[`CSTP_BIT_CKSRC];
        return r;
    endfunction : f_decode

    function automatic logic [7:0] f_ps_term(input logic [1:0] sel);
        logic [7:0] t;
        t = `CSTP_PS_T1;
        case (cstp_pkg::cstp_ps_e'(sel))
            cstp_pkg::CSTP_PS_DIV8: t = `CSTP_PS_T8;
            cstp_pkg::CSTP_PS_DIV64: t = `CSTP_PS_T64;
            cstp_pkg::CSTP_PS_DIV256: t = `CSTP_PS_T256;
            default: t = `CSTP_PS_T1;
        endcase
        return t;
    endfunction : f_ps_term

    // gate only counts with the internal clock
    function automatic logic f_base(
        input cstp_pkg::cstp_ctrl_s c,
        input logic edge_seen,
        input logic gate_in
    );
        return c.clk_src ? edge_seen : (!c.gate || gate_in);
    endfunction : f_base

    // ****************************************
    // clocking and enables
    // ****************************************
    // external pin synchronisers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            ext_q[0] <= 3'h0;
            ext_q[1] <= 3'h0;
        end else begin
            ext_q[0] <= {ext_q[0][1:0], I_LO_EXT_CLK};
            ext_q[1] <= {ext_q[1][1:0], I_HI_EXT_CLK};
        end
    end

    always_comb begin
        ext_edge[0] = ext_q[0][1] & ~ext_q[0][2];
        ext_edge[1] = ext_q[1][1] & ~ext_q[1][2];
        lo_c = f_decode(ctl_q[0]);
        hi_c = f_decode(ctl_q[1]);
        joined = lo_c.pair_join;
        // run gating; idle halt; upper halt joined
        run_en[0] = lo_c.run && !(I_IDLE && (joined ? hi_c.idle_halt : lo_c.idle_halt));
        run_en[1] = !joined && hi_c.run && !(I_IDLE && hi_c.idle_halt);
        // clock source and gate for each timer; gated accumulation
        base_en[0] = run_en[0] && f_base(lo_c, ext_edge[0], I_LO_GATE);
        base_en[1] = run_en[1] && f_base(hi_c, ext_edge[1], I_HI_GATE);
        tick[0] = base_en[0] && (pre_q[0] == f_ps_term(lo_c.prescale));
        tick[1] = base_en[1] && (pre_q[1] == f_ps_term(hi_c.prescale));
        cnt32 = {cnt_q[1], cnt_q[0]};
        per32 = {per_q[1], per_q[0]};
    end

    // ****************************************
    // prescalers
    // ****************************************
    // cleared on a control write so a new ratio starts clean
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            pre_q[0] <= 8'h00;
            pre_q[1] <= 8'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (I_WR && I_ADDR == 4'(i)) begin
                    pre_q[i] <= 8'h00;
                end else if (tick[i]) begin
                    pre_q[i] <= 8'h00;
                end else if (base_en[i]) begin
                    pre_q[i] <= 8'(pre_q[i] + 8'h01);
                end
            end
        end
    end

    // ****************************************
    // counters and period match
    // ****************************************
    // a software write to a count register wins over a tick
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            cnt_q[0] <= `CSTP_CNT_RST;
            cnt_q[1] <= `CSTP_CNT_RST;
            irq_q <= 2'h0;
        end else begin
            irq_q <= 2'h0;
            if (joined) begin
                if (tick[0]) begin
                    if (cnt32 == per32) begin
                        {cnt_q[1], cnt_q[0]} <= 32'h0000_0000;
                        irq_q[1] <= 1'b1;
                    end else begin
                        {cnt_q[1], cnt_q[0]} <= 32'(cnt32 + 32'h0000_0001);
                    end
                end
            end else begin
                for (int i = 0; i < 2; i++) begin
                    if (tick[i]) begin
                        if (cnt_q[i] == per_q[i]) begin
                            cnt_q[i] <= 16'h0000;
                            irq_q[i] <= 1'b1;
                        end else begin
                            cnt_q[i] <= 16'(cnt_q[i] + 16'h0001);
                        end
                    end
                end
            end
            if (I_WR && I_ADDR == `CSTP_OFF_LO_CNT) begin
                cnt_q[0] <= I_WDATA;
            end
            if (I_WR && I_ADDR == `CSTP_OFF_HI_CNT) begin
                cnt_q[1] <= I_WDATA;
            end
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            ctl_q[0] <= `CSTP_CTRL_RST;
            ctl_q[1] <= `CSTP_CTRL_RST;
            per_q[0] <= `CSTP_PER_RST;
            per_q[1] <= `CSTP_PER_RST;
        end else if (I_WR) begin
            case (I_ADDR)
                `CSTP_OFF_LO_CTRL: begin
                    ctl_q[0] <= I_WDATA & `CSTP_LO_CTRL_MASK;
                end
                `CSTP_OFF_HI_CTRL: begin
                    ctl_q[1] <= I_WDATA & `CSTP_HI_CTRL_MASK;
                end
                `CSTP_OFF_LO_PER: begin
                    per_q[0] <= I_WDATA;
                end
                `CSTP_OFF_HI_PER: begin
                    per_q[1] <= I_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    // data valid only in the cycle after the strobe
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            rdata_q <= 16'h0000;
        end else if (I_RD) begin
            case (I_ADDR)
                `CSTP_OFF_LO_CTRL: rdata_q <= ctl_q[0];
                `CSTP_OFF_HI_CTRL: rdata_q <= ctl_q[1];
                `CSTP_OFF_LO_CNT: rdata_q <= cnt_q[0];
                `CSTP_OFF_HI_CNT: rdata_q <= cnt_q[1];
                `CSTP_OFF_LO_PER: rdata_q <= per_q[0];
                `CSTP_OFF_HI_PER: rdata_q <= per_q[1];
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // converter trigger pairs
    assign adc_en = (PAIR_SEL == 0) || (PAIR_SEL == 1);
    // dma from the first pair only
    assign dma_en = (PAIR_SEL == 0);

    assign O_RDATA = rdata_q;
    assign O_LO_PERIOD_IRQ = irq_q[0];
    assign O_HI_PERIOD_IRQ = irq_q[1];
    assign O_ADC_TRIG = adc_en && irq_q[1];
    assign O_DMA_REQ_LO = dma_en && irq_q[0];
    assign O_DMA_REQ_HI = dma_en && irq_q[1];
    // time bases for capture and compare, from the first pair only
    assign O_LO_TIMEBASE = dma_en ? cnt_q[0] : 16'h0000;
    assign O_HI_TIMEBASE = dma_en ? cnt_q[1] : 16'h0000;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_joined_match;
        joined && tick[0] && (cnt32 == per32) && !I_WR;
    endsequence

    sequence s_wrapped_hi;
        (cnt32 == 32'h0000_0000) && O_HI_PERIOD_IRQ;
    endsequence

    sequence s_no_count_write;
        !(I_WR && (I_ADDR == `CSTP_OFF_LO_CNT || I_ADDR == `CSTP_OFF_HI_CNT));
    endsequence

    a_joined_wrap: assert property (
        s_joined_match |=> s_wrapped_hi
    ) else $error("joined match did not wrap and flag");

    a_joined_lo_quiet: assert property (
        $past(joined) && joined |-> !O_LO_PERIOD_IRQ
    ) else $error("lower flag raised while joined");

    a_joined_carry: assert property (
        joined && tick[0] && cnt_q[0] == 16'hffff && cnt32 != per32
        ##0 s_no_count_write
        |=> cnt_q[0] == 16'h0000 && cnt_q[1] == $past(cnt_q[1]) + 16'h0001
    ) else $error("low word carry lost");

    a_stopped_hold: assert property (
        !lo_c.run ##0 s_no_count_write |=> $stable(cnt_q[0])
    ) else $error("lower count moved while stopped");

    a_idle_halt: assert property (
        I_IDLE && !joined && hi_c.idle_halt |-> !tick[1]
    ) else $error("upper timer ticked in idle");

    a_ps_bound: assert property (
        pre_q[0] <= f_ps_term(lo_c.prescale) || $past(I_WR)
    ) else $error("prescaler past its terminal");

    a_ext_edge_only: assert property (
        lo_c.clk_src && base_en[0] |-> $past(I_LO_EXT_CLK, 2) && !$past(I_LO_EXT_CLK, 3)
    ) else $error("external tick without rising edge");

    a_gate_block: assert property (
        !lo_c.clk_src && lo_c.gate && !I_LO_GATE |-> !base_en[0]
    ) else $error("gate low but timer accumulated");

    a_ctrl_unimpl: assert property (
        I_RD && I_ADDR == `CSTP_OFF_HI_CTRL
        |=> (O_RDATA & ~`CSTP_HI_CTRL_MASK) == 16'h0000
    ) else $error("unimplemented control bit read back");

    a_dma_pair: assert property (
        O_DMA_REQ_LO || O_DMA_REQ_HI |-> PAIR_SEL == 0
    ) else $error("dma request from wrong pair");

    a_adc_follow: assert property (
        O_ADC_TRIG |-> O_HI_PERIOD_IRQ && PAIR_SEL < 2
    ) else $error("converter trigger without upper match");

    a_split_lo_wrap: assert property (
        !joined && tick[0] && cnt_q[0] == per_q[0] && !I_WR |=> cnt_q[0] == 16'h0000 && O_LO_PERIOD_IRQ
    ) else $error("lower timer did not wrap and flag");

    a_split_hi_wrap: assert property (
        !joined && tick[1] && cnt_q[1] == per_q[1] && !I_WR |=> cnt_q[1] == 16'h0000 && O_HI_PERIOD_IRQ
    ) else $error("upper timer did not wrap and flag");

    a_joined_early: assert property (
        joined && tick[0] && cnt32 != per32 |=> !O_HI_PERIOD_IRQ
    ) else $error("joined flag raised before period match");

    a_lo_idle: assert property (
        I_IDLE && !joined && lo_c.idle_halt |-> !tick[0]
    ) else $error("lower timer ticked in idle");

    a_joined_idle: assert property (
        I_IDLE && joined && hi_c.idle_halt |-> !tick[0]
    ) else $error("joined timer ticked in idle");

    a_lo_unimpl: assert property (
        I_RD && I_ADDR == `CSTP_OFF_LO_CTRL |=> (O_RDATA & ~`CSTP_LO_CTRL_MASK) == 16'h0000
    ) else $error("unimplemented lower control bit read back");

    // read data must drop back to zero outside the answer cycle
    a_rdata_idle: assert property (
        !$past(I_RD) |-> O_RDATA == 16'h0000
    ) else $error("read data present without a read");

endmodule : cstp_timer_pair

//--- cstp_testbench.sv
`timescale 1ns/10ps
`include "cstp_map.svh"

// ****************************************
// bench for the timer pair
// ****************************************
module testbench;
    logic clk;
    logic rst_b;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr_s;
    logic rd_s;
    logic idle;
    logic lo_ext;
    logic hi_ext;
    logic lo_gate;
    logic hi_gate;
    logic [15:0] rdata;
    logic lo_irq;
    logic hi_irq;
    logic adc_trig;
    logic dma_lo;
    logic dma_hi;
    logic [15:0] lo_tb;
    logic [15:0] hi_tb;
    logic far_adc;
    logic far_dma_lo;
    logic far_dma_hi;
    logic [15:0] far_lo_tb;
    logic [15:0] far_hi_tb;
    int n_fail = 0;
    int total_checks = 0;
    int n_lo = 0;
    int n_hi = 0;
    int cyc = 0;
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h2578777f;
    logic [31:0] note;
    // each note is {mask, expected read data}
    logic [31:0] exp_q[$];
    int rtab[4] = '{1, 8, 64, 256};

    cstp_timer_pair #(.PAIR_SEL(0)) dut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_IDLE(idle),
        .I_LO_EXT_CLK(lo_ext), .I_HI_EXT_CLK(hi_ext), .I_LO_GATE(lo_gate),
        .I_HI_GATE(hi_gate), .O_LO_PERIOD_IRQ(lo_irq), .O_HI_PERIOD_IRQ(hi_irq),
        .O_ADC_TRIG(adc_trig), .O_DMA_REQ_LO(dma_lo), .O_DMA_REQ_HI(dma_hi),
        .O_LO_TIMEBASE(lo_tb), .O_HI_TIMEBASE(hi_tb));

    // second pair on the same stimulus: converter two, no dma, no time base
    cstp_timer_pair #(.PAIR_SEL(1)) dut_far (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(), .I_IDLE(idle),
        .I_LO_EXT_CLK(lo_ext), .I_HI_EXT_CLK(hi_ext), .I_LO_GATE(lo_gate),
        .I_HI_GATE(hi_gate), .O_LO_PERIOD_IRQ(), .O_HI_PERIOD_IRQ(),
        .O_ADC_TRIG(far_adc), .O_DMA_REQ_LO(far_dma_lo), .O_DMA_REQ_HI(far_dma_hi),
        .O_LO_TIMEBASE(far_lo_tb), .O_HI_TIMEBASE(far_hi_tb));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m,
                       input string what);
        total_checks++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // ****************************************
    // register bus master
    // ****************************************
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s <= w;
        rd_s <= r;
        addr <= a;
        wdata <= d;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, a, 16'h0000);
    endtask : rd

    // counts restart from zero; window holds two period-4 matches at ratio r
    task automatic run_win(input logic [15:0] lc, input logic [15:0] hc, input int r,
                           input int e_lo, input int e_hi);
        wr(`CSTP_OFF_LO_CNT, 16'h0000);
        wr(`CSTP_OFF_HI_CNT, 16'h0000);
        wr(`CSTP_OFF_LO_CTRL, lc);
        wr(`CSTP_OFF_HI_CTRL, hc);
        @(negedge clk);
        n_lo = 0;
        n_hi = 0;
        repeat (9 * r - 2) @(posedge clk);
        wr(`CSTP_OFF_LO_CTRL, lc & 16'h7fff);
        wr(`CSTP_OFF_HI_CTRL, hc & 16'h7fff);
        repeat (4) @(posedge clk);
        cmp(16'(n_lo), 16'(e_lo), 16'hffff, "lower irq count");
        cmp(16'(n_hi), 16'(e_hi), 16'hffff, "upper irq count");
    endtask : run_win

    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge clk) begin
        cyc++;
        if (rd_seen) begin
            note = exp_q.pop_front();
            cmp(rdata, note[15:0], note[31:16], "read data");
        end
        rd_seen <= rd_s;
        if (lo_irq === 1'b1)
            n_lo++;
        if (hi_irq === 1'b1)
            n_hi++;
        if (rst_b === 1'b1 && (lo_irq | hi_irq | adc_trig | dma_lo | dma_hi |
            far_adc | far_dma_lo | far_dma_hi) !== 1'b0) begin
            cmp({13'h0, adc_trig, dma_lo, dma_hi}, {13'h0, hi_irq, lo_irq, hi_irq}, 16'hffff,
                "trigger follow");
            cmp({13'h0, far_adc, far_dma_lo, far_dma_hi}, {13'h0, hi_irq, 2'b00}, 16'hffff,
                "far pair triggers");
        end
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        idle = 1'b0;
        lo_ext = 1'b0;
        hi_ext = 1'b0;
        lo_gate = 1'b0;
        hi_gate = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 6; a++)
            rd(4'(a), (a >= 4) ? 16'hffff : 16'h0000, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(`CSTP_OFF_LO_PER, seed[15:0]);
            wr(`CSTP_OFF_HI_CNT, seed[31:16]);
            wr(`CSTP_OFF_LO_CTRL, seed[15:0] & 16'h7fff);
            wr(`CSTP_OFF_HI_CTRL, seed[31:16] & 16'h7fff);
            wr(4'h9, seed[15:0]);
            rd(`CSTP_OFF_LO_PER, seed[15:0], 16'hffff);
            rd(`CSTP_OFF_HI_CNT, seed[31:16], 16'hffff);
            rd(`CSTP_OFF_LO_CTRL, seed[15:0] & 16'h207a, 16'hffff);
            rd(`CSTP_OFF_HI_CTRL, seed[31:16] & 16'h2072, 16'hffff);
            rd(4'h9, 16'h0000, 16'hffff);
        end
        wr(`CSTP_OFF_LO_PER, 16'h0003);
        wr(`CSTP_OFF_HI_PER, 16'h0003);
        for (int p = 0; p < 4; p++)
            run_win(16'h8000 | 16'(p << 4), 16'h0000, rtab[p], 2, 0);
        run_win(16'h0000, 16'h8000, 1, 0, 2);
        run_win(16'h0000, 16'h8010, 8, 0, 2);
        run_win(16'h8040, 16'h8040, 1, 0, 0);
        lo_gate <= 1'b1;
        hi_gate <= 1'b1;
        run_win(16'h8040, 16'h8040, 1, 2, 2);
        idle <= 1'b1;
        run_win(16'ha000, 16'h0000, 1, 0, 0);
        run_win(16'h8000, 16'h0000, 1, 2, 0);
        wr(`CSTP_OFF_HI_PER, 16'h0000);
        // joined: upper control garbage other than the idle halt bit must not matter
        run_win(16'h8008, 16'h0072, 1, 0, 2);
        run_win(16'h8008, 16'h2000, 1, 0, 0);
        run_win(16'ha008, 16'h0000, 1, 0, 2);
        idle <= 1'b0;
        lo_gate <= 1'b0;
        run_win(16'h8048, 16'h0000, 1, 0, 0);
        // external pins; lower gate bit set but gate low is ignored
        wr(`CSTP_OFF_LO_PER, 16'h0001);
        wr(`CSTP_OFF_HI_PER, 16'h0001);
        run_win(16'h0000, 16'h0000, 1, 0, 0);
        wr(`CSTP_OFF_LO_CTRL, 16'h8042);
        wr(`CSTP_OFF_HI_CTRL, 16'h8002);
        @(negedge clk);
        n_lo = 0;
        n_hi = 0;
        repeat (6) begin
            repeat (3) @(posedge clk);
            lo_ext <= 1'b1;
            hi_ext <= 1'b1;
            repeat (3) @(posedge clk);
            lo_ext <= 1'b0;
            hi_ext <= 1'b0;
        end
        repeat (6) @(posedge clk);
        cmp(16'(n_lo), 16'h0003, 16'hffff, "lower ext count");
        cmp(16'(n_hi), 16'h0003, 16'hffff, "upper ext count");
        // carry from low word into high word
        wr(`CSTP_OFF_HI_CTRL, 16'h0000);
        wr(`CSTP_OFF_LO_CTRL, 16'h0008);
        wr(`CSTP_OFF_LO_PER, 16'hffff);
        wr(`CSTP_OFF_HI_PER, 16'h0001);
        wr(`CSTP_OFF_LO_CNT, 16'hfffe);
        wr(`CSTP_OFF_HI_CNT, 16'h0000);
        wr(`CSTP_OFF_LO_CTRL, 16'h8008);
        repeat (4) @(posedge clk);
        wr(`CSTP_OFF_LO_CTRL, 16'h0008);
        rd(`CSTP_OFF_HI_CNT, 16'h0001, 16'hffff);
        rd(`CSTP_OFF_LO_CNT, 16'h0000, 16'hfff0);
        cmp(hi_tb, 16'h0001, 16'hffff, "upper time base");
        cmp(lo_tb, 16'h0000, 16'hfff0, "lower time base");
        cmp(far_lo_tb | far_hi_tb, 16'h0000, 16'hffff, "far time base");
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule : testbench
